/* File: vsr_top.sv */
/*
 * fixed-amount shift datapath: saturating word left shift and arithmetic
 * right shifts (plain or rounded) of four bytes or two halfwords.
 * assumes the pipeline presents instruction and source value together on the
 * core clock with issue_valid_i; results return one clock later.
 */
// How it works
// (RQ1) word shifts left, zeros fill low bits
// (RQ2) overflow when discarded bits differ from sign
// (RQ3) overflow saturates by original sign
// (RQ4) word amount is unsigned five bits
// (RQ5) overflow sets sticky control bit 22
// (RQ6) word form decoded from its fields
// (RQ7) byte lanes shift right, sign filled
// (RQ8) byte rounding keeps one bit, adds one
// (RQ9) byte forms decoded from extension group
// (RQ10) halfword lanes shift right, sign filled
// (RQ11) halfword rounding keeps one bit, adds one
// (RQ12) halfword forms decoded from their fields
// (RQ13) only reserved or disabled exceptions raised
// (RQ14) software supplies correctly packed operands
// (RQ15) zero amount passes lanes, no overflow
`timescale 1ns/100ps
`include "vsr_map.svh"
module vsr_top
	import vsr_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        issue_valid_i,
	input  wire logic [31:0] instr_i,
	input  wire logic [31:0] src_operand_i,
	input  wire logic [31:0] signal_proc_ctrl_i,
	input  wire logic        dsp_present_i,
	input  wire logic        dsp_rev2_i,
	input  wire logic        dsp_enable_i,
	output logic             result_valid_o,
	output logic [31:0]      result_o,
	output logic [4:0]       dest_reg_o,
	output logic             ctrl_we_o,
	output logic [31:0]      ctrl_wdata_o,
	output logic             exc_reserved_o,
	output logic             exc_dsp_disabled_o
);

	////////////////////////////////////////////////////////////////////////
	// decode
	vsr_op_t     op;
	logic        major_ok;
	logic        word_hit;
	logic        byte_grp_hit;
	logic [6:0]  byte_kind;
	logic        half_fmt_ok;
	logic [10:0] half_minor;
	logic [4:0]  w_amt;
	logic [2:0]  b_amt;
	logic [3:0]  h_amt;

	// the forms overlap in bit positions, so each is matched on all of its
	// own fields; no single field identifies one of them
	assign major_ok     = instr_i[`VSR_MAJOR_HI:`VSR_MAJOR_LO] == `VSR_MAJOR_GROUP_A;
	assign word_hit     = !instr_i[`VSR_W_ZERO_BIT] && instr_i[`VSR_W_MINOR_HI:`VSR_W_MINOR_LO] == `VSR_W_MINOR;
	assign byte_grp_hit = instr_i[`VSR_B_GROUP_HI:`VSR_B_GROUP_LO] == `VSR_B_GROUP;
	assign byte_kind    = instr_i[`VSR_B_KIND_HI:`VSR_B_KIND_LO];
	assign half_fmt_ok  = !instr_i[`VSR_H_ZERO_BIT];
	assign half_minor   = instr_i[`VSR_H_MINOR_HI:`VSR_H_MINOR_LO];
	assign w_amt        = instr_i[`VSR_W_AMT_HI:`VSR_W_AMT_LO]; // see (RQ4)
	assign b_amt        = instr_i[`VSR_B_AMT_HI:`VSR_B_AMT_LO];
	assign h_amt        = instr_i[`VSR_H_AMT_HI:`VSR_H_AMT_LO];

	always_comb begin
		op = VSR_OP_NONE;
		if (major_ok) begin
			if (word_hit) begin
				op = VSR_OP_WORD_SAT; // see (RQ6)
			end else if (byte_grp_hit && byte_kind == `VSR_B_PLAIN) begin
				op = VSR_OP_BYTE; // see (RQ9)
			end else if (byte_grp_hit && byte_kind == `VSR_B_ROUND) begin
				op = VSR_OP_BYTE_RND; // see (RQ9)
			end else if (half_fmt_ok && half_minor == `VSR_H_PLAIN) begin
				op = VSR_OP_HALF; // see (RQ12)
			end else if (half_fmt_ok && half_minor == `VSR_H_ROUND) begin
				op = VSR_OP_HALF_RND; // see (RQ12)
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// saturating word left shift
	logic signed [62:0] w_wide;
	logic        [31:0] w_shifted;
	logic        [31:0] w_result;
	logic               w_ovf;

	// the wide copy keeps every shifted-out bit with the sign extended above,
	// so one compare covers both the discarded bits and the new sign bit
	assign w_wide    = $signed({{31{src_operand_i[31]}}, src_operand_i}) <<< w_amt;
	assign w_shifted = src_operand_i << w_amt; // see (RQ1)
	assign w_ovf     = (w_wide[62:31] != {32{src_operand_i[31]}}); // see (RQ2) (RQ15)

	always_comb begin
		if (w_ovf) begin
			w_result = src_operand_i[31] ? `VSR_SAT_NEG : `VSR_SAT_POS; // see (RQ3)
		end else begin
			w_result = w_shifted;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// packed lanes; operands are taken as packed, no format check (RQ14)
	logic [31:0] b_result;
	logic [31:0] h_result;
	logic        b_round;
	logic        h_round;

	assign b_round = (op == VSR_OP_BYTE_RND);
	assign h_round = (op == VSR_OP_HALF_RND);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_byte
			// see (RQ7) (RQ8) (RQ15)
			vsr_lane_shift #(
				.W  (8),
				.SW (3)
			) u_lane (
				.lane_i  (src_operand_i[gi*8 +: 8]),
				.amt_i   (b_amt),
				.round_i (b_round),
				.lane_o  (b_result[gi*8 +: 8])
			);
		end
		for (gi = 0; gi < 2; gi++) begin : g_half
			// see (RQ10) (RQ11) (RQ15)
			vsr_lane_shift #(
				.W  (16),
				.SW (4)
			) u_lane (
				.lane_i  (src_operand_i[gi*16 +: 16]),
				.amt_i   (h_amt),
				.round_i (h_round),
				.lane_o  (h_result[gi*16 +: 16])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// exceptions: availability only, never operand values
	logic is_ours;
	logic need_rev2;
	logic nxt_reserved;
	logic nxt_disabled;
	logic execute;
	logic [31:0] nxt_result;

	assign is_ours      = issue_valid_i && (op != VSR_OP_NONE);
	assign need_rev2    = (op == VSR_OP_BYTE) || (op == VSR_OP_BYTE_RND);
	// reserved wins over disabled: a missing unit cannot be merely switched off
	assign nxt_reserved = is_ours && (!dsp_present_i || (need_rev2 && !dsp_rev2_i)); // see (RQ13)
	assign nxt_disabled = is_ours && !nxt_reserved && !dsp_enable_i; // see (RQ13)
	assign execute      = is_ours && !nxt_reserved && !nxt_disabled;

	always_comb begin
		case (op)
			VSR_OP_WORD_SAT: nxt_result = w_result;
			VSR_OP_BYTE,
			VSR_OP_BYTE_RND: nxt_result = b_result;
			VSR_OP_HALF,
			VSR_OP_HALF_RND: nxt_result = h_result;
			default:         nxt_result = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// register file write-back
	logic [4:0]  nxt_dest;
	logic [31:0] nxt_wb_result;

	// the result bus is held at zero when nothing is written, so a stale lane
	// value never looks like a fresh one
	assign nxt_dest      = instr_i[`VSR_TGT_HI:`VSR_TGT_LO];
	assign nxt_wb_result = execute ? nxt_result : 32'h0000_0000;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_valid_o <= 1'b0;
			result_o       <= 32'h0000_0000;
			dest_reg_o     <= 5'h00;
		end else begin
			result_valid_o <= execute;
			result_o       <= nxt_wb_result;
			dest_reg_o     <= nxt_dest;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky overflow: write only when set, never clear; other bits kept
	logic        nxt_ctrl_we;
	logic [31:0] nxt_ctrl_wdata;

	assign nxt_ctrl_we    = execute && (op == VSR_OP_WORD_SAT) && w_ovf; // see (RQ5)
	assign nxt_ctrl_wdata = signal_proc_ctrl_i | (32'h0000_0001 << `VSR_OUFLAG_BIT); // see (RQ5)

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl_we_o    <= 1'b0;
			ctrl_wdata_o <= 32'h0000_0000;
		end else begin
			ctrl_we_o    <= nxt_ctrl_we;
			ctrl_wdata_o <= nxt_ctrl_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// exception reporting
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			exc_reserved_o     <= 1'b0;
			exc_dsp_disabled_o <= 1'b0;
		end else begin
			exc_reserved_o     <= nxt_reserved;
			exc_dsp_disabled_o <= nxt_disabled;
		end
	end

endmodule // vsr_top

/* File: vsr_map.svh */
/*
 * constants for the fixed-amount shift datapath: opcode fields, minor codes,
 * saturation values and control register bit positions.
 * assumes nothing; included by bare name from the top design file and the testbench.
 */
`ifndef VSR_MAP_SVH
`define VSR_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// instruction fields
`define VSR_MAJOR_HI        31
`define VSR_MAJOR_LO        26
`define VSR_TGT_HI          25
`define VSR_TGT_LO          21
`define VSR_SRC_HI          20
`define VSR_SRC_LO          16
`define VSR_MAJOR_GROUP_A   6'h00

// word shift: amount 15..11, bit 10 zero, minor 9..0
`define VSR_W_AMT_HI        15
`define VSR_W_AMT_LO        11
`define VSR_W_ZERO_BIT      10
`define VSR_W_MINOR         10'h3f5
`define VSR_W_MINOR_HI      9
`define VSR_W_MINOR_LO      0

// byte vector: amount 15..13, kind 12..6, group 5..0
`define VSR_B_AMT_HI        15
`define VSR_B_AMT_LO        13
`define VSR_B_KIND_HI       12
`define VSR_B_KIND_LO       6
`define VSR_B_GROUP_HI      5
`define VSR_B_GROUP_LO      0
`define VSR_B_GROUP         6'h3c
`define VSR_B_PLAIN         7'h07
`define VSR_B_ROUND         7'h47

// halfword pair: amount 15..12, bit 11 zero, minor 10..0
`define VSR_H_AMT_HI        15
`define VSR_H_AMT_LO        12
`define VSR_H_ZERO_BIT      11
`define VSR_H_MINOR_HI      10
`define VSR_H_MINOR_LO      0
`define VSR_H_PLAIN         11'h335
`define VSR_H_ROUND         11'h735

////////////////////////////////////////////////////////////////////////////////
// results and control register
`define VSR_SAT_POS         32'h7fff_ffff
`define VSR_SAT_NEG         32'h8000_0000
`define VSR_OUFLAG_BIT      22

`endif

/* File: vsr_pkg.sv */
/*
 * types shared by the shift datapath modules.
 * assumes vsr_map.svh is on the include path.
 */
package vsr_pkg;
	typedef enum logic [2:0] {
		VSR_OP_NONE,
		VSR_OP_WORD_SAT,
		VSR_OP_BYTE,
		VSR_OP_BYTE_RND,
		VSR_OP_HALF,
		VSR_OP_HALF_RND
	} vsr_op_t;
endpackage

/* File: vsr_lane_shift.sv */
/*
 * one signed lane: arithmetic right shift, optionally rounded.
 * assumes a purely combinational use inside the datapath; same clock domain.
 */
`timescale 1ns/100ps
module vsr_lane_shift
	import vsr_pkg::*;
#(
	parameter int W  = 8,
	parameter int SW = 3
) (
	input  wire logic [W-1:0]  lane_i,
	input  wire logic [SW-1:0] amt_i,
	input  wire logic          round_i,
	output logic      [W-1:0]  lane_o
);
	logic signed [W:0] ext;
	logic signed [W:0] shifted;
	logic        [W:0] rounded;

	// one extra discarded bit kept below the lane; amount zero adds to that
	// bit only, so the lane comes back unchanged
	assign ext     = $signed({lane_i, 1'b0});
	assign shifted = ext >>> amt_i;
	assign rounded = $unsigned(shifted) + (W+1)'(1);

	always_comb begin
		if (round_i) begin
			lane_o = rounded[W:1];
		end else begin
			lane_o = shifted[W:1];
		end
	end
endmodule // vsr_lane_shift

/* File: vsr_top_assertions.sv */
/* port checker for the shift datapath.
 assumes it is bound into vsr_top; one clock, async low reset. */
`timescale 1ns/100ps
module vsr_top_checker (
	input wire logic        clk_i,
	input wire logic        resetn_i,
	input wire logic        issue_valid_i,
	input wire logic [31:0] instr_i,
	input wire logic [31:0] src_operand_i,
	input wire logic [31:0] signal_proc_ctrl_i,
	input wire logic        dsp_present_i,
	input wire logic        dsp_rev2_i,
	input wire logic        dsp_enable_i,
	input wire logic        result_valid_o,
	input wire logic [31:0] result_o,
	input wire logic        ctrl_we_o,
	input wire logic [31:0] ctrl_wdata_o,
	input wire logic        exc_reserved_o,
	input wire logic        exc_dsp_disabled_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	wire is_w = issue_valid_i && instr_i[31:26] == 6'h00 && !instr_i[10] && instr_i[9:0] == 10'h3f5;
	wire ok_w = is_w && dsp_present_i && dsp_enable_i;
	wire is_b = issue_valid_i && instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h3c
		&& (instr_i[12:6] == 7'h07 || instr_i[12:6] == 7'h47);
	wire ok_b = is_b && dsp_present_i && dsp_rev2_i && dsp_enable_i;
	wire is_h = issue_valid_i && instr_i[31:26] == 6'h00 && !instr_i[11]
		&& (instr_i[10:0] == 11'h335 || instr_i[10:0] == 11'h735);
	wire ok_h = is_h && dsp_present_i && dsp_enable_i;
	a_exc_quiet: assert property ((exc_reserved_o || exc_dsp_disabled_o) |-> !result_valid_o && !ctrl_we_o)
		else $error("write beside exception");
	a_exc_single: assert property (!(exc_reserved_o && exc_dsp_disabled_o))
		else $error("two exceptions");
	a_word_answer: assert property (ok_w |=> result_valid_o)
		else $error("word op not answered");
	a_word_absent: assert property (is_w && !dsp_present_i |=> exc_reserved_o && !result_valid_o)
		else $error("missing reserved exception");
	a_sat_sign: assert property (ctrl_we_o |-> result_o == ($past(src_operand_i[31]) ? 32'h8000_0000 : 32'h7fff_ffff))
		else $error("bad saturation value");
	a_flag_merge: assert property (ctrl_we_o |-> ctrl_wdata_o == ($past(signal_proc_ctrl_i) | 32'h0040_0000))
		else $error("bad control write");
	a_zero_amt: assert property (ok_w && instr_i[15:11] == 5'h00 |=> !ctrl_we_o && result_o == $past(src_operand_i))
		else $error("zero shift changed word");
	a_one_shift: assert property (ok_w && instr_i[15:11] == 5'h01 && src_operand_i[31] == src_operand_i[30]
		|=> !ctrl_we_o && result_o == {$past(src_operand_i[30:0]), 1'b0})
		else $error("bad single shift");
	a_byte_zero: assert property (ok_b && instr_i[15:13] == 3'h0 |=> result_valid_o && result_o == $past(src_operand_i))
		else $error("zero byte shift changed lanes");
	a_byte_no_rev: assert property (is_b && dsp_present_i && !dsp_rev2_i |=> exc_reserved_o && !result_valid_o)
		else $error("byte form without reserved exception");
	a_byte_sign_fill: assert property (ok_b && instr_i[12:6] == 7'h07 && instr_i[15:13] == 3'h7
		|=> result_o == {{8{$past(src_operand_i[31])}}, {8{$past(src_operand_i[23])}},
		{8{$past(src_operand_i[15])}}, {8{$past(src_operand_i[7])}}})
		else $error("byte sign fill wrong");
	a_half_zero: assert property (ok_h && instr_i[15:12] == 4'h0 |=> result_valid_o && result_o == $past(src_operand_i))
		else $error("zero halfword shift changed lanes");
	a_no_issue: assert property (!issue_valid_i |=> !result_valid_o && !exc_reserved_o && !exc_dsp_disabled_o)
		else $error("output without issue");
endmodule // vsr_top_checker
bind vsr_top vsr_top_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .issue_valid_i(issue_valid_i),
	.instr_i(instr_i), .src_operand_i(src_operand_i), .signal_proc_ctrl_i(signal_proc_ctrl_i),
	.dsp_present_i(dsp_present_i), .dsp_rev2_i(dsp_rev2_i), .dsp_enable_i(dsp_enable_i),
	.result_valid_o(result_valid_o),
	.result_o(result_o), .ctrl_we_o(ctrl_we_o), .ctrl_wdata_o(ctrl_wdata_o),
	.exc_reserved_o(exc_reserved_o), .exc_dsp_disabled_o(exc_dsp_disabled_o));

/* File: vsr_pipe_model.sv */
/* pipeline-side model: holds the control register the datapath updates.
 assumes the core clock and reset of the datapath. */
`timescale 1ns/100ps
module vsr_pipe_model (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        ctrl_we_i,
	input  wire logic [31:0] ctrl_wdata_i,
	input  wire logic        load_i,
	input  wire logic [31:0] load_val_i,
	output logic      [31:0] ctrl_o
);
	// software reload lets the sticky bit drop again; any word is a legal operand
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) ctrl_o <= 32'h0000_0000;
		else if (load_i) ctrl_o <= load_val_i;
		else if (ctrl_we_i) ctrl_o <= ctrl_wdata_i;
	end
endmodule // vsr_pipe_model

/* File: testbench.sv */
/* self-checking bench: random back-to-back shifts against an integer model.
 assumes vsr_map.svh on the include path; 200 MHz core clock. */
`timescale 1ns/100ps
`include "vsr_map.svh"
module testbench;
	logic clk = 0, rstn = 0, iv = 0, pres = 0, rev2 = 0, en = 0, ld = 0;
	logic [31:0] instr = 0, src = 0, ldv = 0, ctrl, res, cw;
	logic [4:0] dst;
	logic rv, cwe, exr, exd, e_v = 0, e_r = 0, e_d = 0, e_we = 0;
	logic [31:0] e_res = 0, e_cw = 0;
	logic [4:0] e_dst = 0;
	int seed = 8, mismatches = 0, n_checks = 0, k, s, tg;
	longint lr;
	always #2.5 clk = ~clk;
	vsr_top dut (.clk_i(clk), .resetn_i(rstn), .issue_valid_i(iv), .instr_i(instr), .src_operand_i(src),
		.signal_proc_ctrl_i(ctrl), .dsp_present_i(pres), .dsp_rev2_i(rev2), .dsp_enable_i(en),
		.result_valid_o(rv), .result_o(res), .dest_reg_o(dst), .ctrl_we_o(cwe), .ctrl_wdata_o(cw),
		.exc_reserved_o(exr), .exc_dsp_disabled_o(exd));
	vsr_pipe_model pipe (.clk_i(clk), .resetn_i(rstn), .ctrl_we_i(cwe), .ctrl_wdata_i(cw), .load_i(ld),
		.load_val_i(ldv), .ctrl_o(ctrl));
	////////////////////////////////////////////////////////////////////////////
	function automatic int lane(int v, int w, int sh, bit r);
		v = (v << (32 - w)) >>> (32 - w);
		if (sh != 0 && r) v = ((v >>> (sh - 1)) + 1) >>> 1;
		else v = v >>> sh;
		return v & ((1 << w) - 1);
	endfunction
	task automatic chk1(logic g, logic e);
		n_checks++;
		if (g !== e) begin mismatches++; $display("CHECK FAILED at %0t: flag %b not %b", $time, g, e); end
	endtask
	task automatic chk32(logic [31:0] g, logic [31:0] e);
		n_checks++;
		if (g !== e) begin mismatches++; $display("CHECK FAILED at %0t: word %h not %h", $time, g, e); end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1;
		repeat (1500) begin
			@(posedge clk);
			k = {$random(seed)} % 6;
			s = $random(seed) & 31;
			tg = $random(seed) & 15;
			iv <= tg != 3;
			pres <= tg != 0;
			rev2 <= tg != 1;
			en <= tg != 2;
			ld <= tg == 4;
			ldv <= $random(seed);
			src <= $random(seed);
			tg = $random(seed) & 31;
			case (k)
				0: instr <= {6'h00, tg[4:0], 5'h01, s[4:0], 1'b0, `VSR_W_MINOR};
				1, 2: instr <= {6'h00, tg[4:0], 5'h01, s[2:0], k == 2 ? `VSR_B_ROUND : `VSR_B_PLAIN, `VSR_B_GROUP};
				3, 4: instr <= {6'h00, tg[4:0], 5'h01, s[3:0], 1'b0, k == 4 ? `VSR_H_ROUND : `VSR_H_PLAIN};
				default: instr <= {6'h01, tg[4:0], 5'h01, s[4:0], 1'b0, `VSR_W_MINOR};
			endcase
			@(negedge clk);
			chk1(rv, e_v);
			chk1(exr, e_r);
			chk1(exd, e_d);
			chk1(cwe, e_we);
			chk32(res, e_res);
			if (e_v) chk32({27'h0, dst}, {27'h0, e_dst});
			if (e_we) chk32(cw, e_cw);
			e_r = iv && k < 5 && (!pres || (k == 1 || k == 2) && !rev2);
			e_d = iv && k < 5 && !e_r && !en;
			e_v = iv && k < 5 && !e_r && !e_d;
			e_dst = tg[4:0];
			e_cw = ctrl | 32'h0040_0000;
			lr = longint'($signed(src)) <<< s;
			e_we = e_v && k == 0 && (lr >>> 31) != 0 && (lr >>> 31) != -1;
			if (!e_v) e_res = 0;
			else if (k == 0) e_res = e_we ? (src[31] ? `VSR_SAT_NEG : `VSR_SAT_POS) : lr[31:0];
			else if (k < 3) for (int i = 0; i < 4; i++) e_res[8*i +: 8] = 8'(lane(src[8*i +: 8], 8, s & 7, k == 2));
			else for (int i = 0; i < 2; i++) e_res[16*i +: 16] = 16'(lane(src[16*i +: 16], 16, s & 15, k == 4));
		end
		print_verdict();
	end
endmodule // testbench
